// File: rtl/bmw_regs.sv
// Memory and prefetchable window registers of one bridge port, AHB-Lite slave.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module bmw_regs
    import bmw_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Transaction address to classify, 64 bits, same clock domain
    input  wire logic        txn_valid,
    input  wire logic        txn_is_64,
    input  wire logic [63:0] txn_addr,
    // Registered forwarding decision
    output logic             fwd_valid,
    output logic             fwd_mem_hit,
    output logic             fwd_pf_hit
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Inclusive range test shared by both windows.
    function automatic logic bmw_in_range(input logic [63:0] a,
                                          input logic [63:0] lo,
                                          input logic [63:0] hi);
        bmw_in_range = (a >= lo) && (a <= hi);
    endfunction : bmw_in_range

    // Byte offset decode of a word address.
    function automatic logic bmw_is(input logic [31:0] a,
                                    input logic [7:0] ofs);
        bmw_is = (a[31:2] == {24'h000000, ofs[7:2]});
    endfunction : bmw_is

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    // Window fields; only the writable bits are stored, because the
    // indicator nibbles are constants of the read mux.
    logic [11:0] mem_bot_reg, mem_bot_next;
    logic [11:0] mem_top_reg, mem_top_next;
    logic [11:0] pf_bot_reg, pf_bot_next;
    logic [11:0] pf_top_reg, pf_top_next;
    logic [31:0] pf_bot_hi_reg, pf_bot_hi_next;
    logic [31:0] pf_top_hi_reg, pf_top_hi_next;

    // Captured address phase.
    logic        wr_pend_reg, wr_pend_next;
    logic [31:0] wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;

    // Forwarding decision.
    logic        fwd_valid_reg, fwd_valid_next;
    bmw_hit_t    hit_reg, hit_next;

    logic        phase_ok;
    bmw_bounds_t bounds;

    assign phase_ok = hsel && hready && (htrans == BMW_HTRANS_NSEQ);

    // Expanded bounds from the stored fields.
    always_comb begin
        bounds.mem_bottom = {mem_bot_reg, BMW_LOW_ZERO};
        bounds.mem_top    = {mem_top_reg, BMW_LOW_ONES};
        bounds.pf_bottom  = {pf_bot_hi_reg, pf_bot_reg,
                             BMW_LOW_ZERO};
        bounds.pf_top     = {pf_top_hi_reg, pf_top_reg,
                             BMW_LOW_ONES};
    end

    // Read mux for the word addressed in the address phase.
    function automatic logic [31:0] bmw_read(input logic [31:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (bmw_is(a, BMW_OFS_MEM)) begin
            v[BMW_BOT_LSB +: 12] = mem_bot_reg;
            v[BMW_TOP_LSB +: 12] = mem_top_reg;
        end else if (bmw_is(a, BMW_OFS_PF_LOW)) begin
            v[BMW_IND_BOT_LSB +: 4] = BMW_IND_64;
            v[BMW_BOT_LSB +: 12]    = pf_bot_reg;
            v[BMW_IND_TOP_LSB +: 4] = BMW_IND_64;
            v[BMW_TOP_LSB +: 12]    = pf_top_reg;
        end else if (bmw_is(a, BMW_OFS_PF_BOT_H)) begin
            v = pf_bot_hi_reg;
        end else if (bmw_is(a, BMW_OFS_PF_TOP_H)) begin
            v = pf_top_hi_reg;
        end else begin
            v = 32'h0000_0000;
        end
        bmw_read = v;
    endfunction : bmw_read

    // ------------------------------------------------------------------
    // Bus and register next state
    // ------------------------------------------------------------------
    // Writes land in the data phase; reads are sampled in the address
    // phase so the slave never inserts wait states.
    always_comb begin
        mem_bot_next   = mem_bot_reg;
        mem_top_next   = mem_top_reg;
        pf_bot_next    = pf_bot_reg;
        pf_top_next    = pf_top_reg;
        pf_bot_hi_next = pf_bot_hi_reg;
        pf_top_hi_next = pf_top_hi_reg;
        wr_pend_next   = phase_ok && hwrite;
        wr_addr_next   = phase_ok ? haddr : wr_addr_reg;
        rdata_next     = (phase_ok && !hwrite) ? bmw_read(haddr)
                                               : 32'h0000_0000;
        if (wr_pend_reg) begin
            if (bmw_is(wr_addr_reg, BMW_OFS_MEM)) begin
                mem_bot_next = hwdata[BMW_BOT_LSB +: 12];
                mem_top_next = hwdata[BMW_TOP_LSB +: 12];
            end else if (bmw_is(wr_addr_reg, BMW_OFS_PF_LOW)) begin
                pf_bot_next = hwdata[BMW_BOT_LSB +: 12];
                pf_top_next = hwdata[BMW_TOP_LSB +: 12];
            end else if (bmw_is(wr_addr_reg, BMW_OFS_PF_BOT_H)) begin
                pf_bot_hi_next = hwdata;
            end else if (bmw_is(wr_addr_reg, BMW_OFS_PF_TOP_H)) begin
                pf_top_hi_next = hwdata;
            end else begin
                mem_bot_next = mem_bot_reg;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_bot_reg   <= BMW_FIELD_RST;
            mem_top_reg   <= BMW_FIELD_RST;
            pf_bot_reg    <= BMW_FIELD_RST;
            pf_top_reg    <= BMW_FIELD_RST;
            pf_bot_hi_reg <= BMW_UPPER_RST;
            pf_top_hi_reg <= BMW_UPPER_RST;
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 32'h0000_0000;
            rdata_reg     <= 32'h0000_0000;
        end else begin
            mem_bot_reg   <= mem_bot_next;
            mem_top_reg   <= mem_top_next;
            pf_bot_reg    <= pf_bot_next;
            pf_top_reg    <= pf_top_next;
            pf_bot_hi_reg <= pf_bot_hi_next;
            pf_top_hi_reg <= pf_top_hi_next;
            wr_pend_reg   <= wr_pend_next;
            wr_addr_reg   <= wr_addr_next;
            rdata_reg     <= rdata_next;
        end
    end

    // The slave never stalls and never reports an error, yet ready and
    // response still come from flops so that every output is registered.
    logic        ready_reg, ready_next;
    logic        resp_reg, resp_next;

    always_comb begin
        ready_next = 1'b1;
        resp_next  = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_reg <= 1'b1;
            resp_reg  <= 1'b0;
        end else begin
            ready_reg <= ready_next;
            resp_reg  <= resp_next;
        end
    end

    // Read data stands only in the data phase and is zero otherwise.
    assign hrdata    = rdata_reg;
    assign hreadyout = ready_reg;
    assign hresp     = resp_reg;

    // ------------------------------------------------------------------
    // Forwarding decision
    // ------------------------------------------------------------------
    // A 32-bit address never reaches the prefetch window above 4 GB, so
    // the upper half is forced to zero when the request is narrow.
    always_comb begin
        logic [63:0] a;
        a = txn_is_64 ? txn_addr : {32'h0000_0000, txn_addr[31:0]};
        fwd_valid_next   = txn_valid;
        hit_next.mem_hit = txn_valid && !txn_is_64 &&
            bmw_in_range(a, {32'h0000_0000, bounds.mem_bottom},
                         {32'h0000_0000, bounds.mem_top});
        hit_next.pf_hit  = txn_valid &&
            bmw_in_range(a, bounds.pf_bottom, bounds.pf_top);
    end

    // Register the decision; the outputs follow txn_valid one cycle later, for as many cycles as it is held.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fwd_valid_reg <= 1'b0;
            hit_reg       <= '0;
        end else begin
            fwd_valid_reg <= fwd_valid_next;
            hit_reg       <= hit_next;
        end
    end

    // Outputs come straight from the decision flops.
    assign fwd_valid   = fwd_valid_reg;
    assign fwd_mem_hit = hit_reg.mem_hit;
    assign fwd_pf_hit  = hit_reg.pf_hit;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Every check but hit_valid_a looks one edge back: both the read data and the
    // forwarding decision are registered one cycle after their cause.

    // Bus side: indicator nibbles read back and every write lands.
    ind_read_a: assert property (
        $past(phase_ok && !hwrite && bmw_is(haddr, BMW_OFS_PF_LOW)) |->
        hrdata[3:0] == BMW_IND_64 && hrdata[19:16] == BMW_IND_64)
        else $error("64-bit indicator not 0001b");
    mem_bot_write_a: assert property (
        wr_pend_reg && bmw_is(wr_addr_reg, BMW_OFS_MEM) |=>
        mem_bot_reg == $past(hwdata[15:4]))
        else $error("memory window bottom write lost");
    mem_top_write_a: assert property (
        wr_pend_reg && bmw_is(wr_addr_reg, BMW_OFS_MEM) |=>
        mem_top_reg == $past(hwdata[31:20]))
        else $error("memory window top write lost");
    pf_bot_write_a: assert property (
        wr_pend_reg && bmw_is(wr_addr_reg, BMW_OFS_PF_LOW) |=>
        pf_bot_reg == $past(hwdata[15:4]))
        else $error("prefetch window bottom write lost");
    pf_top_write_a: assert property (
        wr_pend_reg && bmw_is(wr_addr_reg, BMW_OFS_PF_LOW) |=>
        pf_top_reg == $past(hwdata[31:20]))
        else $error("prefetch window top write lost");
    bot_hi_write_a: assert property (
        wr_pend_reg && bmw_is(wr_addr_reg, BMW_OFS_PF_BOT_H) |=>
        pf_bot_hi_reg == $past(hwdata))
        else $error("prefetch bottom upper write lost");
    top_hi_write_a: assert property (
        wr_pend_reg && bmw_is(wr_addr_reg, BMW_OFS_PF_TOP_H) |=>
        pf_top_hi_reg == $past(hwdata))
        else $error("prefetch top upper write lost");

    // Forwarding side: a memory hit or a wide prefetch hit lies inside its window, a narrow memory miss outside the memory window.
    mem_hit_range_a: assert property (
        fwd_mem_hit |->
        $past(txn_addr[31:0]) >= $past(bounds.mem_bottom) &&
        $past(txn_addr[31:0]) <= $past(bounds.mem_top))
        else $error("memory hit outside window");
    mem_miss_a: assert property (
        fwd_valid && !fwd_mem_hit && !$past(txn_is_64) |->
        $past(txn_addr[31:0]) < $past(bounds.mem_bottom) ||
        $past(txn_addr[31:0]) > $past(bounds.mem_top))
        else $error("memory miss inside window");
    pf_hit_range_a: assert property (
        fwd_pf_hit && $past(txn_is_64) |->
        $past(txn_addr) >= $past(bounds.pf_bottom) &&
        $past(txn_addr) <= $past(bounds.pf_top))
        else $error("prefetch hit outside window");
    pf_hit_order_a: assert property (
        fwd_pf_hit |-> $past(bounds.pf_bottom) <= $past(bounds.pf_top))
        else $error("prefetch hit in empty window");
    hit_valid_a: assert property (
        fwd_pf_hit || fwd_mem_hit |-> fwd_valid)
        else $error("hit without valid");

    // Main scenarios; the bench reaches all but wr_then_rd_c, as no read address phase directly follows a write data phase.
    mem_hit_c: cover property (fwd_mem_hit);
    pf_hit_c: cover property (fwd_pf_hit && $past(txn_is_64));
    wr_then_rd_c: cover property (wr_pend_reg ##1 phase_ok && !hwrite);
    miss_both_c: cover property (fwd_valid && !fwd_mem_hit && !fwd_pf_hit);
    pf_ind_rd_c: cover property (
        $past(phase_ok && !hwrite && bmw_is(haddr, BMW_OFS_PF_LOW)));

endmodule : bmw_regs

`default_nettype wire

// File: shared/bmw_pkg.sv
// Package of offsets, field layouts and types for the bridge memory window registers.
package bmw_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] BMW_OFS_MEM      = 8'h20;
    localparam logic [7:0] BMW_OFS_PF_LOW   = 8'h24;
    localparam logic [7:0] BMW_OFS_PF_BOT_H = 8'h28;
    localparam logic [7:0] BMW_OFS_PF_TOP_H = 8'h2c;

    // ------------------------------------------------------------------
    // Field positions and fixed values
    // ------------------------------------------------------------------
    localparam int         BMW_BOT_LSB      = 4;
    localparam int         BMW_TOP_LSB      = 20;
    localparam int         BMW_IND_BOT_LSB  = 0;
    localparam int         BMW_IND_TOP_LSB  = 16;
    localparam logic [3:0] BMW_IND_64       = 4'h1;
    localparam logic [11:0] BMW_FIELD_RST   = 12'h000;
    localparam logic [31:0] BMW_UPPER_RST   = 32'h0000_0000;
    localparam logic [19:0] BMW_LOW_ZERO    = 20'h00000;
    localparam logic [19:0] BMW_LOW_ONES    = 20'hfffff;

    // AHB transfer type for a non-sequential transfer.
    localparam logic [1:0] BMW_HTRANS_NSEQ  = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Expanded window bounds as seen by the forwarding logic.
    typedef struct packed {
        logic [31:0] mem_bottom;
        logic [31:0] mem_top;
        logic [63:0] pf_bottom;
        logic [63:0] pf_top;
    } bmw_bounds_t;

    // Forwarding decision for one transaction address.
    typedef struct packed {
        logic mem_hit;
        logic pf_hit;
    } bmw_hit_t;

endpackage : bmw_pkg

// File: verification/bridge_memory_window_regs_test.sv
// Self-checking testbench for the bridge memory window registers.
`timescale 1ns/10ps
`default_nettype none

module bridge_memory_window_regs_test;
    import bmw_pkg::*;

    // ------------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------------
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        txn_valid;
    logic        txn_is_64;
    logic [63:0] txn_addr;
    logic        fwd_valid;
    logic        fwd_mem_hit;
    logic        fwd_pf_hit;
    logic [31:0] rd;
    wire logic   hready = hreadyout;
    int          errors;
    int          checks;

    // One register case: address, word written, word expected on readback.
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
    } bmw_row_t;

    // Reserved bits read zero and the 64-bit indicators stay at one.
    localparam bmw_row_t ROWS [0:6] = '{
        '{32'h0000_0020, 32'hffff_ffff, 32'hfff0_fff0},
        '{32'h0000_0024, 32'hffff_ffff, 32'hfff1_fff1},
        '{32'h0000_0024, 32'h0000_0000, 32'h0001_0001},
        '{32'h0000_0028, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
        '{32'h0000_002c, 32'h5a5a_a5a5, 32'h5a5a_a5a5},
        '{32'h0000_0030, 32'hffff_ffff, 32'h0000_0000},
        '{32'h0000_0020, 32'h4560_1230, 32'h4560_1230}
    };

    bmw_regs bmw_regs_i (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hready      (hready),
        .hwdata      (hwdata),
        .hrdata      (hrdata),
        .hreadyout   (hreadyout),
        .hresp       (hresp),
        .txn_valid   (txn_valid),
        .txn_is_64   (txn_is_64),
        .txn_addr    (txn_addr),
        .fwd_valid   (fwd_valid),
        .fwd_mem_hit (fwd_mem_hit),
        .fwd_pf_hit  (fwd_pf_hit)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compares with case equality so an unknown never passes.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t ns: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Ends when hready is high; the watchdog stops a stuck slave from hanging us.
    task automatic wait_ready();
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
    endtask : wait_ready

    // One single-word transfer; entered just after a rising edge.
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] data);
        haddr  <= a;
        hwrite <= wr;
        htrans <= BMW_HTRANS_NSEQ;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        data = hrdata;
        check({hreadyout, hresp}, 2'b10);
    endtask : bus

    // Presents one address and checks the decision one cycle later.
    task automatic classify(input logic w64, input logic [63:0] a,
                            input logic em, input logic ep);
        txn_valid <= 1'b1;
        txn_is_64 <= w64;
        txn_addr  <= a;
        @(posedge hclk);
        txn_valid <= 1'b0;
        @(negedge hclk);
        check({fwd_valid, fwd_mem_hit, fwd_pf_hit}, {1'b1, em, ep});
        @(posedge hclk);
    endtask : classify

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // The tests need under a hundred cycles; fifty times that means a hang.
    initial begin
        repeat (5000) @(posedge hclk);
        errors++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {hresetn, htrans, hwrite, haddr, hwdata} = '0;
        {txn_valid, txn_is_64, txn_addr} = '0;
        hsel   = 1'b1;
        hsize  = 3'h2;
        errors = 0;
        checks = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        // Cleared bounds give both windows 0..fffff, inclusive at the top.
        classify(1'b0, 64'h0000_0000_000f_ffff, 1'b1, 1'b1);
        classify(1'b0, 64'h0000_0000_0010_0000, 1'b0, 1'b0);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, ROWS[i].addr, ROWS[i].wdata, rd);
            @(posedge hclk);
            bus(1'b0, ROWS[i].addr, 32'h0, rd);
            check(rd, ROWS[i].rdata);
        end
        // Memory window 1230_0000..456f_ffff;
        // prefetch window 1_7ff0_0000..2_800f_ffff.
        bus(1'b1, 32'h0000_0024, 32'h8000_7ff0, rd);
        bus(1'b1, 32'h0000_0028, 32'h0000_0001, rd);
        bus(1'b1, 32'h0000_002c, 32'h0000_0002, rd);
        @(posedge hclk);
        classify(1'b0, 64'h0000_0000_1230_0000, 1'b1, 1'b0);
        classify(1'b0, 64'h0000_0000_122f_ffff, 1'b0, 1'b0);
        classify(1'b0, 64'h0000_0000_456f_ffff, 1'b1, 1'b0);
        classify(1'b0, 64'h0000_0000_4570_0000, 1'b0, 1'b0);
        classify(1'b0, 64'hffff_ffff_1230_0000, 1'b1, 1'b0);
        classify(1'b1, 64'h0000_0001_7ff0_0000, 1'b0, 1'b1);
        classify(1'b1, 64'h0000_0001_7fef_ffff, 1'b0, 1'b0);
        classify(1'b1, 64'h0000_0002_800f_ffff, 1'b0, 1'b1);
        classify(1'b1, 64'h0000_0002_8010_0000, 1'b0, 1'b0);
        classify(1'b1, 64'h0000_0000_1230_0000, 1'b0, 1'b0);
        @(negedge hclk);
        check({63'h0, fwd_valid}, 64'h0);
        // Mid-run reset must clear every writable field again.
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check({32'h0, hrdata}, 64'h0);
        hresetn <= 1'b1;
        bus(1'b0, 32'h0000_0020, 32'h0, rd);
        check({32'h0, rd}, 64'h0);
        bus(1'b0, 32'h0000_0024, 32'h0, rd);
        check({32'h0, rd}, 64'h0001_0001);
        bus(1'b0, 32'h0000_0028, 32'h0, rd);
        check({32'h0, rd}, 64'h0);
        bus(1'b0, 32'h0000_002c, 32'h0, rd);
        check({32'h0, rd}, 64'h0);
        print_verdict();
    end

endmodule : bridge_memory_window_regs_test

`default_nettype wire
